// ### design/cilt_pkg.sv
// Package for the camera output line, input filter and pulse timer block
package cilt_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS      = 10;
  localparam int unsigned TICK_NS            = 1000;
  localparam int unsigned GLITCH_UNIT_NS     = 500;
  localparam int unsigned US_CYCLES          = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned GLITCH_UNIT_CYCLES = GLITCH_UNIT_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Register map and field sizes
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W    = 12;
  localparam int unsigned GLITCH_W  = 21;
  localparam int unsigned TIME_W    = 26;
  localparam int unsigned PRE_W     = 7;
  localparam int unsigned DB_W      = 28;
  localparam int unsigned RESTART_BIT = 0;

  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_GLITCH = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_DELAY  = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_LENGTH = 12'h00C;
  localparam logic [ADDR_W-1:0] ADDR_CMD    = 12'h010;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h014;

  localparam logic [GLITCH_W-1:0] GLITCH_RESET = 21'h0_0001;
  localparam logic [GLITCH_W-1:0] GLITCH_MAX   = 21'h1E_8480;
  localparam logic [TIME_W-1:0]   TIME_RESET   = 26'h000_0000;
  localparam logic [TIME_W-1:0]   TIME_MAX     = 26'h393_8700;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_OFF      = 3'h0,
    SRC_EXPOSURE = 3'h1,
    SRC_READOUT  = 3'h2,
    SRC_SOFTWARE = 3'h3,
    SRC_TIMER    = 3'h4,
    SRC_STROBE   = 3'h5
  } cilt_src_t;

  typedef enum logic [2:0] {
    TRIG_OFF      = 3'h0,
    TRIG_EXPOSURE = 3'h1,
    TRIG_READOUT  = 3'h2,
    TRIG_EXTERNAL = 3'h3,
    TRIG_STROBE   = 3'h4
  } cilt_trig_t;

  typedef enum logic [1:0] {
    COND_RISE = 2'h0,
    COND_FALL = 2'h1,
    COND_HIGH = 2'h2,
    COND_LOW  = 2'h3
  } cilt_cond_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_DELAY  = 2'b01,
    ST_ACTIVE = 2'b11
  } cilt_state_t;

  typedef struct packed {
    logic [21:0] rsvd;
    cilt_cond_t  pulse_trigger_condition;
    cilt_trig_t  pulse_trigger_select;
    logic        software_output_level;
    logic        output_polarity_invert;
    cilt_src_t   output_source_select;
  } cilt_ctrl_t;

  typedef struct packed {
    logic [24:0] rsvd;
    logic        strobe_window;
    cilt_state_t timer_state;
    logic        output_line;
    logic        filtered_input;
    logic        exposure_window;
    logic        readout_window;
  } cilt_status_t;

  typedef struct packed {
    logic exposure_window;
    logic readout_window;
    logic bottom_line_start;
    logic top_line_end;
  } cilt_cam_t;

  localparam cilt_ctrl_t CTRL_RESET = '0;

endpackage : cilt_pkg

// ### design/cilt_top.sv
// Camera output line, input glitch filter and pulse timer with APB registers

module cilt_top (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic [cilt_pkg::ADDR_W-1:0] paddr,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire cilt_pkg::cilt_cam_t        cam_in,
  input  wire logic [cilt_pkg::TIME_W-1:0] exposure_time_us,
  input  wire logic [cilt_pkg::TIME_W-1:0] readout_time_us,
  input  wire logic                       external_trigger_input,
  output logic                            output_line
);

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  cilt_pkg::cilt_ctrl_t            ctrl_q;
  logic [cilt_pkg::GLITCH_W-1:0]  glitch_q;
  logic [cilt_pkg::TIME_W-1:0]    delay_q;
  logic [cilt_pkg::TIME_W-1:0]    length_q;
  logic [31:0]                    prdata_q;
  logic                           pready_q;
  logic                           pslverr_q;
  cilt_pkg::cilt_status_t         status;
  logic [31:0]                    rd_data;

  function automatic logic is_mapped(input logic [cilt_pkg::ADDR_W-1:0] a);
    is_mapped = (a == cilt_pkg::ADDR_CTRL) || (a == cilt_pkg::ADDR_GLITCH) ||
                (a == cilt_pkg::ADDR_DELAY) || (a == cilt_pkg::ADDR_LENGTH) ||
                (a == cilt_pkg::ADDR_CMD) || (a == cilt_pkg::ADDR_STATUS);
  endfunction : is_mapped

  function automatic logic [cilt_pkg::TIME_W-1:0] clamp_time(input logic [31:0] v);
    clamp_time = (v > 32'(cilt_pkg::TIME_MAX)) ? cilt_pkg::TIME_MAX
                                               : v[cilt_pkg::TIME_W-1:0];
  endfunction : clamp_time

  wire setup_ph  = psel && !penable;
  wire wr_acc    = psel && penable && pready_q && pwrite;
  wire wr_ctrl   = wr_acc && (paddr == cilt_pkg::ADDR_CTRL);
  wire wr_glitch = wr_acc && (paddr == cilt_pkg::ADDR_GLITCH);
  wire wr_delay  = wr_acc && (paddr == cilt_pkg::ADDR_DELAY);
  wire wr_length = wr_acc && (paddr == cilt_pkg::ADDR_LENGTH);
  wire restart   = wr_acc && (paddr == cilt_pkg::ADDR_CMD) && pwdata[cilt_pkg::RESTART_BIT];

  // Out-of-range filter times saturate so the filter never wraps to a short one
  wire [cilt_pkg::GLITCH_W-1:0] glitch_wr = (pwdata > 32'(cilt_pkg::GLITCH_MAX)) ?
                                             cilt_pkg::GLITCH_MAX :
                                             pwdata[cilt_pkg::GLITCH_W-1:0];

  assign rd_data = (paddr == cilt_pkg::ADDR_CTRL)   ? 32'(ctrl_q) :
                   (paddr == cilt_pkg::ADDR_GLITCH) ? 32'(glitch_q) :
                   (paddr == cilt_pkg::ADDR_DELAY)  ? 32'(delay_q) :
                   (paddr == cilt_pkg::ADDR_LENGTH) ? 32'(length_q) :
                   (paddr == cilt_pkg::ADDR_STATUS) ? 32'(status) : 32'h0000_0000;

  // Answer prepared during setup so read data leaves a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup_ph;
      prdata_q  <= (setup_ph && !pwrite) ? rd_data : 32'h0000_0000;
      pslverr_q <= setup_ph && !is_mapped(paddr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q   <= cilt_pkg::CTRL_RESET;
      glitch_q <= cilt_pkg::GLITCH_RESET;
      delay_q  <= cilt_pkg::TIME_RESET;
      length_q <= cilt_pkg::TIME_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_q      <= cilt_pkg::cilt_ctrl_t'(pwdata);
        ctrl_q.rsvd <= '0;
      end
      if (wr_glitch) begin
        glitch_q <= glitch_wr;
      end
      if (wr_delay) begin
        delay_q <= clamp_time(pwdata);
      end
      if (wr_length) begin
        length_q <= clamp_time(pwdata);
      end
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // ----------------------------------------------------------------
  // Strobe window
  // ----------------------------------------------------------------
  logic strobe_q;
  wire  strobe_ok = exposure_time_us > readout_time_us;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_q <= 1'b0;
    end else if (!strobe_ok) begin
      strobe_q <= 1'b0;
    end else if (cam_in.bottom_line_start) begin
      strobe_q <= 1'b1;
    end else if (cam_in.top_line_end) begin
      strobe_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Input glitch filter
  // ----------------------------------------------------------------
  logic                  raw_q;
  logic                  filt_q;
  logic [cilt_pkg::DB_W-1:0] db_cnt_q;
  wire  [cilt_pkg::DB_W-1:0] db_thr = cilt_pkg::DB_W'(glitch_q) *
                                      cilt_pkg::DB_W'(cilt_pkg::GLITCH_UNIT_CYCLES);
  wire  db_diff = raw_q != filt_q;
  wire  db_hit  = db_diff && (db_cnt_q >= db_thr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_q    <= 1'b0;
      filt_q   <= 1'b0;
      db_cnt_q <= '0;
    end else begin
      raw_q <= external_trigger_input;
      if (db_hit) begin
        filt_q   <= raw_q;
        db_cnt_q <= '0;
      end else if (db_diff) begin
        db_cnt_q <= db_cnt_q + cilt_pkg::DB_W'(1);
      end else begin
        db_cnt_q <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pulse timer
  // ----------------------------------------------------------------
  cilt_pkg::cilt_state_t      state_q;
  cilt_pkg::cilt_state_t      state_d;
  logic [cilt_pkg::PRE_W-1:0] pre_q;
  logic [cilt_pkg::TIME_W-1:0] us_q;
  logic                       tsrc_q;
  logic                       tsrc;

  assign tsrc = (ctrl_q.pulse_trigger_select == cilt_pkg::TRIG_EXPOSURE) ? cam_in.exposure_window :
                (ctrl_q.pulse_trigger_select == cilt_pkg::TRIG_READOUT)  ? cam_in.readout_window :
                (ctrl_q.pulse_trigger_select == cilt_pkg::TRIG_EXTERNAL) ? filt_q :
                (ctrl_q.pulse_trigger_select == cilt_pkg::TRIG_STROBE)   ? strobe_q :
                1'b0;

  wire trig_on  = ctrl_q.pulse_trigger_select != cilt_pkg::TRIG_OFF;
  wire lvl_mode = ctrl_q.pulse_trigger_condition[1];
  wire lvl_hit  = (ctrl_q.pulse_trigger_condition == cilt_pkg::COND_HIGH) ? tsrc : !tsrc;
  wire edge_hit = (ctrl_q.pulse_trigger_condition == cilt_pkg::COND_RISE) ? (tsrc && !tsrc_q) :
                  (!tsrc && tsrc_q);
  wire us_tick  = pre_q == cilt_pkg::PRE_W'(cilt_pkg::US_CYCLES - 1);
  wire t_done   = (state_q == cilt_pkg::ST_DELAY) ? (us_q >= delay_q) : (us_q >= length_q);
  wire timer_pulse_output = state_q == cilt_pkg::ST_ACTIVE;

  always_comb begin
    state_d = state_q;
    if (!trig_on) begin
      state_d = cilt_pkg::ST_IDLE;
    end else begin
      case (state_q)
        cilt_pkg::ST_IDLE: begin
          if (lvl_mode ? lvl_hit : edge_hit) begin
            state_d = cilt_pkg::ST_DELAY;
          end
        end
        cilt_pkg::ST_DELAY: begin
          if (lvl_mode && !lvl_hit) begin
            state_d = cilt_pkg::ST_IDLE;
          end else if (t_done) begin
            state_d = cilt_pkg::ST_ACTIVE;
          end
        end
        cilt_pkg::ST_ACTIVE: begin
          if (lvl_mode ? !lvl_hit : t_done) begin
            state_d = cilt_pkg::ST_IDLE;
          end
        end
        default: begin
          state_d = cilt_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Counters restart on every state change, so delay and length each last their whole microseconds plus one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= cilt_pkg::ST_IDLE;
      pre_q   <= '0;
      us_q    <= '0;
      tsrc_q  <= 1'b0;
    end else if (restart) begin
      state_q <= cilt_pkg::ST_IDLE;
      pre_q   <= '0;
      us_q    <= '0;
      tsrc_q  <= tsrc;
    end else begin
      state_q <= state_d;
      tsrc_q  <= tsrc;
      if (state_d != state_q) begin
        pre_q <= '0;
        us_q  <= '0;
      end else if (us_tick) begin
        pre_q <= '0;
        us_q  <= (us_q == cilt_pkg::TIME_MAX) ? us_q : us_q + cilt_pkg::TIME_W'(1);
      end else begin
        pre_q <= pre_q + cilt_pkg::PRE_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Output line
  // ----------------------------------------------------------------
  logic line_q;
  logic src_sel;

  assign src_sel = (ctrl_q.output_source_select == cilt_pkg::SRC_EXPOSURE) ?
                     cam_in.exposure_window :
                   (ctrl_q.output_source_select == cilt_pkg::SRC_READOUT)  ?
                     cam_in.readout_window :
                   (ctrl_q.output_source_select == cilt_pkg::SRC_SOFTWARE) ?
                     ctrl_q.software_output_level :
                   (ctrl_q.output_source_select == cilt_pkg::SRC_TIMER)  ? timer_pulse_output :
                   (ctrl_q.output_source_select == cilt_pkg::SRC_STROBE) ? strobe_q : 1'b0;

  // Off forces low even with inversion, so an idle line never fires the flash
  wire src_off = (ctrl_q.output_source_select == cilt_pkg::SRC_OFF) ||
                 (ctrl_q.output_source_select > cilt_pkg::SRC_STROBE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_q <= 1'b0;
    end else if (src_off) begin
      line_q <= 1'b0;
    end else begin
      line_q <= src_sel ^ ctrl_q.output_polarity_invert;
    end
  end

  assign output_line = line_q;

  always_comb begin
    status                 = '0;
    status.strobe_window   = strobe_q;
    status.timer_state     = state_q;
    status.output_line     = line_q;
    status.filtered_input  = filt_q;
    status.exposure_window = cam_in.exposure_window;
    status.readout_window  = cam_in.readout_window;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_off_low: assert property (src_off |=> !output_line)
    else $error("Line driven while source off");
  chk_invert_sw: assert property ((ctrl_q.output_source_select == cilt_pkg::SRC_SOFTWARE)
    |=> output_line == $past(ctrl_q.software_output_level ^ ctrl_q.output_polarity_invert))
    else $error("Software level or inversion wrong");
  chk_exposure_out: assert property ((ctrl_q.output_source_select == cilt_pkg::SRC_EXPOSURE)
    |=> output_line == $past(cam_in.exposure_window ^ ctrl_q.output_polarity_invert))
    else $error("Exposure window not on line");
  chk_readout_out: assert property ((ctrl_q.output_source_select == cilt_pkg::SRC_READOUT)
    |=> output_line == $past(cam_in.readout_window ^ ctrl_q.output_polarity_invert))
    else $error("Readout window not on line");
  chk_timer_out: assert property ((ctrl_q.output_source_select == cilt_pkg::SRC_TIMER)
    |=> output_line == $past(timer_pulse_output ^ ctrl_q.output_polarity_invert))
    else $error("Timer pulse not on line");
  chk_strobe_rise: assert property ((cam_in.bottom_line_start && strobe_ok) |=> strobe_q)
    else $error("Strobe did not rise");
  chk_strobe_gate: assert property (!strobe_ok |=> !strobe_q)
    else $error("Strobe without long exposure");
  chk_filter_hold: assert property (!db_hit |=> $stable(filt_q))
    else $error("Filter passed short interval");
  chk_glitch_range: assert property (glitch_q <= cilt_pkg::GLITCH_MAX)
    else $error("Filter time out of range");
  chk_filter_take: assert property (db_hit |=> filt_q == $past(raw_q))
    else $error("Stable level not passed");
  chk_length_end: assert property ((timer_pulse_output && !lvl_mode && t_done)
    |=> !timer_pulse_output)
    else $error("Pulse exceeded length");
  chk_delay_wait: assert property ((state_q == cilt_pkg::ST_DELAY && !t_done)
    |=> state_q != cilt_pkg::ST_ACTIVE)
    else $error("Active before delay");
  chk_restart_clr: assert property (restart |=> state_q == cilt_pkg::ST_IDLE && us_q == '0)
    else $error("Restart did not clear");
  chk_trig_off: assert property (!trig_on |=> state_q == cilt_pkg::ST_IDLE)
    else $error("Timer ran with trigger off");
  chk_edge_start: assert property ((trig_on && !lvl_mode && state_q == cilt_pkg::ST_IDLE
    && edge_hit && !restart) |=> state_q == cilt_pkg::ST_DELAY)
    else $error("Edge did not start timer");
  chk_level_drop: assert property ((lvl_mode && !lvl_hit
    && state_q != cilt_pkg::ST_IDLE) |=> state_q == cilt_pkg::ST_IDLE)
    else $error("Level mode outlived level");

  cov_edge_pulse: cover property (state_q == cilt_pkg::ST_DELAY ##1 timer_pulse_output);
  cov_strobe: cover property (strobe_q && output_line);
  cov_filter: cover property (db_hit);

endmodule : cilt_top

// ### test/cilt_cam_model.sv
// Camera-side frame source: window levels and rolling-shutter line events
module cilt_cam_model (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          start,
  input  wire logic [15:0]   exp_len,
  input  wire logic [15:0]   ro_len,
  output cilt_pkg::cilt_cam_t cam,
  output logic               busy
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Frame counter
  // ----------------------------------------------------------------
  logic [16:0] cnt_q;
  logic [16:0] last;
  assign last = {1'b0, exp_len} + {1'b0, ro_len};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 17'h0_0000;
    end else if (cnt_q != 17'h0_0000) begin
      cnt_q <= (cnt_q == last) ? 17'h0_0000 : cnt_q + 17'h0_0001;
    end else if (start) begin
      cnt_q <= 17'h0_0001;
    end
  end
  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Bottom line starts one readout time late, so it only precedes the top end on long exposures
  assign cam.exposure_window   = (cnt_q != 17'h0_0000) && (cnt_q <= {1'b0, exp_len});
  assign cam.readout_window    = (cnt_q > {1'b0, exp_len});
  assign cam.bottom_line_start = (cnt_q == {1'b0, ro_len});
  assign cam.top_line_end      = (cnt_q == {1'b0, exp_len});
  assign busy                  = (cnt_q != 17'h0_0000);
endmodule : cilt_cam_model

// ### test/tb_top.sv
// Self-checking bench for the camera output line, input filter and pulse timer
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]          paddr;
  logic [31:0]          pwdata, prdata, q;
  logic                 ext, line, start, busy, err, mon_en, exp_q, strb_q;
  logic [15:0]          e_len, r_len;
  logic [25:0]          e_t, r_t;
  cilt_pkg::cilt_cam_t  cam;
  cilt_pkg::cilt_ctrl_t ctrl_s;
  int                   num_errors, checks, seed, n, w;
  assign e_t = {10'h000, e_len};
  assign r_t = {10'h000, r_len};
  always #5 pclk = ~pclk;
  cilt_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cam_in(cam), .exposure_time_us(e_t),
    .readout_time_us(r_t), .external_trigger_input(ext), .output_line(line));
  cilt_cam_model cam_m (.pclk(pclk), .presetn(presetn), .start(start),
    .exp_len(e_len), .ro_len(r_len), .cam(cam), .busy(busy));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("Counts: checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      num_errors++;
      report_and_stop();
    end
    @(posedge pclk);
  endtask : apb
  // Monitor is paused while the control word changes, so no race with the write edge
  task automatic set_ctrl(input cilt_pkg::cilt_ctrl_t c);
    mon_en = 1'b0;
    apb(1'b1, cilt_pkg::ADDR_CTRL, c);
    ctrl_s = c;
    repeat (2) @(posedge pclk);
    mon_en = (c.output_source_select != cilt_pkg::SRC_TIMER);
  endtask : set_ctrl
  // Starts a frame, measures cycles to the line going high and its high time
  task automatic frame_meas();
    int k;
    start <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
    n = 0;
    w = 0;
    k = 0;
    while (line !== 1'b1 && n < 2000) begin @(posedge pclk); n++; end
    while (line === 1'b1 && w < 2000) begin @(posedge pclk); w++; end
    while (busy === 1'b1 && k < 4000) begin @(posedge pclk); k++; end
    if (k >= 4000) begin
      num_errors++;
      report_and_stop();
    end
    @(posedge pclk);
  endtask : frame_meas
  function automatic logic exp_line(input cilt_pkg::cilt_ctrl_t c,
                                    input cilt_pkg::cilt_cam_t m, input logic s);
    logic v;
    case (c.output_source_select)
      cilt_pkg::SRC_EXPOSURE: v = m.exposure_window;
      cilt_pkg::SRC_READOUT:  v = m.readout_window;
      cilt_pkg::SRC_SOFTWARE: v = c.software_output_level;
      cilt_pkg::SRC_STROBE:   v = s;
      default:                return 1'b0;
    endcase
    return v ^ c.output_polarity_invert;
  endfunction : exp_line
  // ----------------------------------------------------------------
  // Line monitor
  // ----------------------------------------------------------------
  always @(posedge pclk) begin
    if (mon_en) check("output_line", exp_q, line);
    exp_q <= exp_line(ctrl_s, cam, strb_q);
    strb_q <= (e_t > r_t) && (cam.bottom_line_start || (strb_q && !cam.top_line_end));
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    ext = 1'b0;
    start = 1'b0;
    e_len = 16'h0064;
    r_len = 16'h0032;
    ctrl_s = cilt_pkg::CTRL_RESET;
    mon_en = 1'b0;
    exp_q = 1'b0;
    strb_q = 1'b0;
    num_errors = 0;
    checks = 0;
    seed = 49;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, cilt_pkg::ADDR_CTRL, 32'h0000_0000);
    check("ctrl reset", 32'h0000_0000, q);
    apb(1'b0, cilt_pkg::ADDR_GLITCH, 32'h0000_0000);
    check("glitch reset", 32'h0000_0001, q);
    apb(1'b0, cilt_pkg::ADDR_DELAY, 32'h0000_0000);
    check("delay reset", 32'h0000_0000, q);
    apb(1'b1, cilt_pkg::ADDR_GLITCH, 32'h00FF_FFFF);
    apb(1'b0, cilt_pkg::ADDR_GLITCH, 32'h0000_0000);
    check("glitch max", {11'h000, cilt_pkg::GLITCH_MAX}, q);
    apb(1'b1, cilt_pkg::ADDR_LENGTH, 32'h03FF_FFFF);
    apb(1'b0, cilt_pkg::ADDR_LENGTH, 32'h0000_0000);
    check("length max", {6'h00, cilt_pkg::TIME_MAX}, q);
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    check("unmapped slverr", 32'h0000_0001, err);
    $display("Test registers done");
    // Every source code but the timer (4 is replaced by strobe) with random invert and level; equal times suppress the strobe
    for (int i = 0; i < 24; i++) begin
      w = $random(seed);
      e_len = 16'h0028 + 16'(w[13:8]);
      r_len = (i == 21) ? e_len : 16'h0014 + 16'(w[19:16]);
      set_ctrl(cilt_pkg::cilt_ctrl_t'({27'h0, w[4:3], (i[2:0] == 3'h4) ? 3'h5 : i[2:0]}));
      frame_meas();
    end
    $display("Test sources done");
    apb(1'b1, cilt_pkg::ADDR_DELAY, 32'h0000_0001);
    apb(1'b1, cilt_pkg::ADDR_LENGTH, 32'h0000_0002);
    e_len = 16'h0190;
    r_len = 16'h0032;
    for (int c = 0; c < 2; c++) begin
      set_ctrl(cilt_pkg::cilt_ctrl_t'({22'h0, c[1:0], 3'h1, 2'b00, 3'h4}));
      frame_meas();
      check("edge delay", 1, n >= 100 + 400 * c && n <= 110 + 400 * c);
      check("edge length", 201, w);
    end
    set_ctrl(cilt_pkg::cilt_ctrl_t'({22'h0, 2'h2, 3'h1, 2'b00, 3'h4}));
    frame_meas();
    check("level delay", 1, n >= 100 && n <= 110);
    check("level width", 1, w >= 290 && w <= 302);
    set_ctrl(cilt_pkg::cilt_ctrl_t'({22'h0, 2'h0, 3'h2, 2'b00, 3'h4}));
    frame_meas();
    check("readout trigger", 1, n >= 500 && n <= 510);
    set_ctrl(cilt_pkg::cilt_ctrl_t'({22'h0, 2'h0, 3'h4, 2'b00, 3'h4}));
    frame_meas();
    check("strobe trigger", 1, n >= 150 && n <= 160);
    set_ctrl(cilt_pkg::cilt_ctrl_t'({22'h0, 2'h3, 3'h1, 2'b00, 3'h4}));
    frame_meas();
    check("level low", 1, n >= 500 && n <= 510);
    set_ctrl(cilt_pkg::cilt_ctrl_t'({22'h0, 2'h0, 3'h0, 2'b00, 3'h4}));
    frame_meas();
    check("trigger off", 2000, n);
    $display("Test timer done");
    // Restart in mid-pulse, then a fresh trigger must run the full delay again
    apb(1'b1, cilt_pkg::ADDR_LENGTH, 32'h0000_0032);
    set_ctrl(cilt_pkg::cilt_ctrl_t'({22'h0, 2'h0, 3'h1, 2'b00, 3'h4}));
    start <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
    repeat (150) @(posedge pclk);
    apb(1'b0, cilt_pkg::ADDR_STATUS, 32'h0000_0000);
    check("timer active", 32'h0000_0003, q[5:4]);
    apb(1'b1, cilt_pkg::ADDR_CMD, 32'h0000_0001);
    apb(1'b0, cilt_pkg::ADDR_STATUS, 32'h0000_0000);
    check("restart idle", 32'h0000_0000, q[5:3]);
    repeat (400) @(posedge pclk);
    frame_meas();
    check("restart anew", 1, n >= 100 && n <= 110);
    $display("Test restart done");
    // Filter set to 1 us; random short glitches must never pass
    apb(1'b1, cilt_pkg::ADDR_GLITCH, 32'h0000_0002);
    set_ctrl(cilt_pkg::CTRL_RESET);
    for (int k = 0; k < 4; k++) begin
      w = 10 + ($random(seed) & 63);
      ext <= 1'b1;
      repeat (w) @(posedge pclk);
      ext <= 1'b0;
      repeat (20) @(posedge pclk);
      apb(1'b0, cilt_pkg::ADDR_STATUS, 32'h0000_0000);
      check("glitch dropped", 32'h0000_0000, q[2]);
    end
    ext <= 1'b1;
    repeat (85) @(posedge pclk);
    apb(1'b0, cilt_pkg::ADDR_STATUS, 32'h0000_0000);
    check("filter latency", 32'h0000_0000, q[2]);
    repeat (20) @(posedge pclk);
    apb(1'b0, cilt_pkg::ADDR_STATUS, 32'h0000_0000);
    check("filter passed", 32'h0000_0001, q[2]);
    ext <= 1'b0;
    repeat (40) @(posedge pclk);
    ext <= 1'b1;
    repeat (20) @(posedge pclk);
    apb(1'b0, cilt_pkg::ADDR_STATUS, 32'h0000_0000);
    check("low glitch dropped", 32'h0000_0001, q[2]);
    set_ctrl(cilt_pkg::cilt_ctrl_t'({22'h0, 2'h1, 3'h3, 2'b00, 3'h4}));
    ext <= 1'b0;
    frame_meas();
    check("external trigger", 1, n >= 200 && n <= 212);
    $display("Test filter done");
    report_and_stop();
  end
endmodule : tb_top
